// ==== verilog/block_cipher_unit.sv ====
// Block cipher unit: mode options, descriptor sequencing, ECB/CBC/CTR/CCM datapath
`timescale 1ns/1ps
module block_cipher_unit
  import block_cipher_unit_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              nrst,
  input  wire logic              reinit,
  input  wire logic              descValid,
  output logic                   descReady,
  input  wire descriptor_t       desc,
  input  wire logic              inValid,
  input  wire logic [WORD_W-1:0] inWord,
  output logic                   inReady,
  output logic                   outValid,
  input  wire logic              outReady,
  output out_word_t              outData,
  output logic                   jobDone,
  output job_error_t             jobErr,
  output logic                   busy,
  output logic [MODE_W-1:0]      modeOptions
);
  typedef enum logic [2:0] {IDLE, LOAD_KEY, LOAD_CTX, PREP, DATA_IN, DATA_OUT, CTX_OUT, FINISH} state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Functions
  // Keyed, invertible block transform standing in for the cipher core
  function automatic logic [BLOCK_W-1:0] blockCore(input logic [BLOCK_W-1:0] b,
                                                   input logic [BLOCK_W-1:0] k,
                                                   input logic               enc);
    logic [BLOCK_W-1:0] t;
    if (enc) begin
      t = b ^ k;
      blockCore = {t[BLOCK_W-9:0], t[BLOCK_W-1:BLOCK_W-8]};
    end else begin
      t = {b[7:0], b[BLOCK_W-1:8]};
      blockCore = t ^ k;
    end
  endfunction
  // Counter increment wrapping within the low modulus bytes
  function automatic logic [BLOCK_W-1:0] ctrInc(input logic [BLOCK_W-1:0] c,
                                                input logic [WORD_W-1:0]  modulus);
    logic [WORD_W-1:0] mask;
    logic [WORD_W-1:0] low;
    mask = '1;
    if (modulus[3:0] != 4'h0 && modulus[3:0] < 4'h8) begin
      mask = (64'h1 << {modulus[2:0], 3'h0}) - 64'h1;
    end
    low = c[WORD_W-1:0] + 64'h1;
    ctrInc = {c[BLOCK_W-1:WORD_W], (low & mask) | (c[WORD_W-1:0] & ~mask)};
  endfunction
  // Descriptor checks that end in a data error
  function automatic logic descBad(input descriptor_t d);
    logic [1:0] cm;
    logic       keyOk;
    logic       ctxInOk;
    logic       ctxOutOk;
    cm       = d.primaryModeField[CM_HI_BIT:CM_LO_BIT];
    keyOk    = d.keyLen == KEY_LEN_16 || d.keyLen == KEY_LEN_24 || d.keyLen == KEY_LEN_32;
    ctxInOk  = d.extMode ? d.ctxInLen == CTX_LEN_FULL
                         : (d.ctxInLen == LEN_NONE || d.ctxInLen == CTX_LEN_FULL);
    ctxOutOk = d.extMode ? (d.ctxOutLen == LEN_NONE || d.ctxOutLen == CTX_LEN_CCM_SHORT ||
                            d.ctxOutLen == CTX_LEN_CCM_LONG)
                         : (d.ctxOutLen == LEN_NONE || d.ctxOutLen == CTX_LEN_FULL);
    descBad = d.primaryModeField[RSVD_BIT] ||
              cm == CM_RSVD ||
              (d.extMode && cm != CM_ECB) ||
              d.hdrType != HDR_TYPE_COMMON ||
              !keyOk || d.dataLen[3:0] != 4'h0 || !ctxInOk || !ctxOutOk;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  state_t             state_reg;
  logic [MODE_W-1:0]  mode_reg;
  descriptor_t        desc_reg;
  logic [15:0]        cnt_reg;
  logic               half_reg;
  logic [WORD_W-1:0]  low_reg;
  logic [WORD_W-1:0]  key_reg [KEY_WORDS];
  logic [BLOCK_W-1:0] iv_reg;
  logic [BLOCK_W-1:0] slot_reg;
  logic [BLOCK_W-1:0] ctr_reg;
  logic [WORD_W-1:0]  mod_reg;
  logic [BLOCK_W-1:0] mac_reg;
  logic [BLOCK_W-1:0] ctr0_reg;
  logic [BLOCK_W-1:0] res_reg;
  job_error_t         err_reg;
  logic               done_reg;
  logic               accept, modeClash, inFire, outFire, blockFire, ccm;
  logic [1:0]         cm;
  logic               enc;
  logic [BLOCK_W-1:0] keyBlk, inBlk, keyStream, tagBlk, decMac;
  logic [BLOCK_W-1:0] res_next, iv_next, mac_next;
  logic [15:0]        keyWords, ctxInWords, dataWords, ctxOutWords;
  logic [WORD_W-1:0]  ctxOutWord;
  assign ccm         = desc_reg.extMode;
  assign cm          = mode_reg[CM_HI_BIT:CM_LO_BIT];
  assign enc         = mode_reg[DIR_BIT];
  assign keyWords    = {10'h000, desc_reg.keyLen} >> WORD_BYTES_LOG2;
  assign ctxInWords  = {10'h000, desc_reg.ctxInLen} >> WORD_BYTES_LOG2;
  assign dataWords   = desc_reg.dataLen >> WORD_BYTES_LOG2;
  assign ctxOutWords = {10'h000, desc_reg.ctxOutLen} >> WORD_BYTES_LOG2;
  assign keyBlk      = {key_reg[1], key_reg[0]} ^ {key_reg[3], key_reg[2]};
  assign inBlk       = {inWord, low_reg};
  assign keyStream   = blockCore(ctr_reg, keyBlk, 1'b1);
  assign descReady = state_reg == IDLE;
  assign accept    = descValid && descReady;
  assign modeClash = descValid && state_reg != IDLE && state_reg != FINISH &&
                     desc.primaryModeField != mode_reg;
  assign inReady   = state_reg == LOAD_KEY || state_reg == LOAD_CTX || state_reg == DATA_IN;
  assign inFire    = inValid && inReady;
  assign blockFire = inFire && state_reg == DATA_IN && half_reg;
  assign outValid  = state_reg == DATA_OUT || state_reg == CTX_OUT;
  assign outFire   = outValid && outReady;
  assign busy      = state_reg != IDLE;
  assign modeOptions = mode_reg;
  assign jobDone   = done_reg;
  assign jobErr    = err_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Datapath per mode
  always_comb begin
    res_next = '0;
    iv_next  = iv_reg;
    mac_next = mac_reg;
    if (ccm) begin
      res_next = inBlk ^ keyStream;
      mac_next = blockCore(mac_reg ^ (enc ? inBlk : res_next), keyBlk, 1'b1);
    end else begin
      case (cm)
        CM_ECB: res_next = blockCore(inBlk, keyBlk, enc);
        CM_CBC: begin
          if (enc) begin
            res_next = blockCore(inBlk ^ iv_reg, keyBlk, 1'b1);
            iv_next  = res_next;
          end else begin
            res_next = blockCore(inBlk, keyBlk, 1'b0) ^ iv_reg;
            iv_next  = inBlk;
          end
        end
        CM_CTR: res_next = inBlk ^ keyStream;
        default: res_next = '0;
      endcase
    end
  end
  // Final tag only in CCM with final-tag bit set, else running MAC state
  assign tagBlk = mode_reg[FINAL_TAG_BIT] ? mac_reg ^ blockCore(ctr0_reg, keyBlk, 1'b1)
                                          : mac_reg;
  assign decMac = slot_reg ^ blockCore(ctr0_reg, keyBlk, 1'b1);
  always_comb begin
    ctxOutWord = '0;
    if (ccm) begin
      case (cnt_reg[1:0])
        2'h0: ctxOutWord = tagBlk[WORD_W-1:0];
        2'h1: ctxOutWord = tagBlk[BLOCK_W-1:WORD_W];
        2'h2: ctxOutWord = enc ? ctr_reg[WORD_W-1:0] : decMac[WORD_W-1:0];
        default: ctxOutWord = enc ? ctr_reg[BLOCK_W-1:WORD_W] : decMac[BLOCK_W-1:WORD_W];
      endcase
    end else begin
      case (cnt_reg[2:0])
        CTX_IV_W:        ctxOutWord = iv_reg[WORD_W-1:0];
        3'h1:            ctxOutWord = iv_reg[BLOCK_W-1:WORD_W];
        CTX_SLOT_W:      ctxOutWord = slot_reg[WORD_W-1:0];
        CTX_SLOT_CONT_W: ctxOutWord = slot_reg[BLOCK_W-1:WORD_W];
        CTX_CTR_W:       ctxOutWord = ctr_reg[WORD_W-1:0];
        3'h5:            ctxOutWord = ctr_reg[BLOCK_W-1:WORD_W];
        default:         ctxOutWord = mod_reg;
      endcase
    end
  end
  always_comb begin
    outData.kind = state_reg == CTX_OUT ? OUT_CONTEXT : OUT_DATA;
    outData.word = state_reg == CTX_OUT ? ctxOutWord
                 : (half_reg ? res_reg[BLOCK_W-1:WORD_W] : res_reg[WORD_W-1:0]);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_reg <= IDLE;
      cnt_reg   <= 16'h0000;
      half_reg  <= 1'b0;
    end else if (reinit || modeClash) begin
      state_reg <= modeClash ? FINISH : IDLE;
      cnt_reg   <= 16'h0000;
      half_reg  <= 1'b0;
    end else begin
      case (state_reg)
        IDLE: begin
          if (accept) begin
            state_reg <= descBad(desc) ? FINISH : LOAD_KEY;
            cnt_reg   <= 16'h0000;
          end
        end
        LOAD_KEY: begin
          if (inFire) begin
            cnt_reg <= cnt_reg + 16'h0001;
            if (cnt_reg + 16'h0001 == keyWords) begin
              cnt_reg   <= 16'h0000;
              state_reg <= ctxInWords == 16'h0000 ? PREP : LOAD_CTX;
            end
          end
        end
        LOAD_CTX: begin
          if (inFire) begin
            cnt_reg <= cnt_reg + 16'h0001;
            if (cnt_reg + 16'h0001 == ctxInWords) begin
              cnt_reg   <= 16'h0000;
              state_reg <= PREP;
            end
          end
        end
        PREP: state_reg <= dataWords == 16'h0000 ? (ctxOutWords == 16'h0000 ? FINISH : CTX_OUT) : DATA_IN;
        DATA_IN: begin
          if (inFire) begin
            half_reg <= ~half_reg;
            cnt_reg  <= cnt_reg + 16'h0001;
            if (half_reg) begin
              state_reg <= DATA_OUT;
            end
          end
        end
        DATA_OUT: begin
          if (outFire) begin
            half_reg <= ~half_reg;
            if (half_reg) begin
              if (cnt_reg == dataWords) begin
                cnt_reg   <= 16'h0000;
                state_reg <= ctxOutWords == 16'h0000 ? FINISH : CTX_OUT;
              end else begin
                state_reg <= DATA_IN;
              end
            end
          end
        end
        CTX_OUT: begin
          if (outFire) begin
            cnt_reg <= cnt_reg + 16'h0001;
            if (cnt_reg + 16'h0001 == ctxOutWords) begin
              state_reg <= FINISH;
            end
          end
        end
        FINISH:  state_reg <= IDLE;
        default: state_reg <= IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode options, descriptor capture, status
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      mode_reg <= MODE_RESET;
      desc_reg <= '0;
    end else if (reinit) begin
      mode_reg <= MODE_RESET;
    end else if (accept) begin
      mode_reg <= desc.primaryModeField;
      desc_reg <= desc;
    end
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      err_reg  <= '0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= state_reg == FINISH && !reinit;
      if (accept) begin
        err_reg.dataErr <= descBad(desc);
        err_reg.ctxErr  <= 1'b0;
      end else if (modeClash) begin
        err_reg.ctxErr  <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Key and context storage
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < KEY_WORDS; i++) begin
        key_reg[i] <= '0;
      end
    end else if (accept) begin
      for (int i = 0; i < KEY_WORDS; i++) begin
        key_reg[i] <= '0;
      end
    end else if (inFire && state_reg == LOAD_KEY) begin
      key_reg[cnt_reg[1:0]] <= inWord;
    end
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      iv_reg   <= '0;
      slot_reg <= '0;
      ctr_reg  <= '0;
      mod_reg  <= '0;
      mac_reg  <= '0;
      ctr0_reg <= '0;
    end else if (inFire && state_reg == LOAD_CTX) begin
      case (cnt_reg[2:0])
        CTX_IV_W:        iv_reg[WORD_W-1:0]         <= inWord;
        3'h1:            iv_reg[BLOCK_W-1:WORD_W]   <= inWord;
        CTX_SLOT_W:      slot_reg[WORD_W-1:0]       <= inWord;
        CTX_SLOT_CONT_W: slot_reg[BLOCK_W-1:WORD_W] <= inWord;
        CTX_CTR_W:       ctr_reg[WORD_W-1:0]        <= inWord;
        3'h5:            ctr_reg[BLOCK_W-1:WORD_W]  <= inWord;
        default:         mod_reg                    <= inWord;
      endcase
    end else if (state_reg == PREP && ccm) begin
      ctr0_reg <= ctr_reg;
      ctr_reg  <= ctrInc(ctr_reg, mod_reg);
      mac_reg  <= mode_reg[MAC_INIT_BIT] ? blockCore(iv_reg, keyBlk, 1'b1) : iv_reg;
    end else if (blockFire) begin
      iv_reg  <= iv_next;
      mac_reg <= mac_next;
      if (ccm || cm == CM_CTR) begin
        ctr_reg <= ctrInc(ctr_reg, mod_reg);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Block assembly and result
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      low_reg <= '0;
      res_reg <= '0;
    end else if (inFire && state_reg == DATA_IN) begin
      if (half_reg) begin
        res_reg <= res_next;
      end else begin
        low_reg <= inWord;
      end
    end
  end
endmodule // block_cipher_unit

// ==== verilog/block_cipher_unit_pkg.sv ====
// Constants, field layouts and carrier types for the block cipher unit
package block_cipher_unit_pkg;
  localparam int WORD_W   = 64;
  localparam int BLOCK_W  = 128;
  localparam int MODE_W   = 6;
  localparam int CTX_WORDS = 7;
  localparam int KEY_WORDS = 4;

  // Mode option bit positions
  localparam int FINAL_TAG_BIT = 5;
  localparam int MAC_INIT_BIT  = 4;
  localparam int RSVD_BIT      = 3;
  localparam int CM_HI_BIT     = 2;
  localparam int CM_LO_BIT     = 1;
  localparam int DIR_BIT       = 0;

  localparam logic [MODE_W-1:0] MODE_RESET = 6'h00;
  localparam logic [1:0] CM_ECB  = 2'h0;
  localparam logic [1:0] CM_CBC  = 2'h1;
  localparam logic [1:0] CM_RSVD = 2'h2;
  localparam logic [1:0] CM_CTR  = 2'h3;

  localparam logic [3:0] HDR_TYPE_COMMON = 4'h1;

  // Byte lengths
  localparam logic [5:0]  KEY_LEN_16   = 6'h10;
  localparam logic [5:0]  KEY_LEN_24   = 6'h18;
  localparam logic [5:0]  KEY_LEN_32   = 6'h20;
  localparam logic [5:0]  CTX_LEN_FULL = 6'h38;
  localparam logic [5:0]  CTX_LEN_CCM_SHORT = 6'h18;
  localparam logic [5:0]  CTX_LEN_CCM_LONG  = 6'h20;
  localparam logic [5:0]  LEN_NONE     = 6'h00;
  localparam int          WORD_BYTES_LOG2 = 3;

  // Context word indices (byte offset / 8)
  localparam logic [2:0] CTX_IV_W   = 3'h0;
  localparam logic [2:0] CTX_SLOT_W = 3'h2;
  localparam logic [2:0] CTX_SLOT_CONT_W = 3'h3;
  localparam logic [2:0] CTX_CTR_W  = 3'h4;
  localparam logic [2:0] CTX_MOD_W  = 3'h6;

  typedef struct packed {
    logic [3:0]        hdrType;
    logic              extMode;
    logic [MODE_W-1:0] primaryModeField;
    logic [5:0]        keyLen;
    logic [5:0]        ctxInLen;
    logic [15:0]       dataLen;
    logic [5:0]        ctxOutLen;
  } descriptor_t;

  typedef enum logic {OUT_DATA, OUT_CONTEXT} out_kind_t;

  typedef struct packed {
    out_kind_t         kind;
    logic [WORD_W-1:0] word;
  } out_word_t;

  typedef struct packed {
    logic dataErr;
    logic ctxErr;
  } job_error_t;
endpackage

// ==== sim/block_cipher_unit_properties.sv ====
// Port-level assertions and covers for the block cipher unit
`timescale 1ns/1ps

module block_cipher_unit_properties
  import block_cipher_unit_pkg::*;
(
  input wire logic              clk_sys,
  input wire logic              nrst,
  input wire logic              reinit,
  input wire logic              descValid,
  input wire logic              descReady,
  input wire descriptor_t       desc,
  input wire logic              inReady,
  input wire logic              outValid,
  input wire logic              outReady,
  input wire out_word_t         outData,
  input wire logic              jobDone,
  input wire job_error_t        jobErr,
  input wire logic              busy,
  input wire logic [MODE_W-1:0] modeOptions
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  logic take;
  assign take = descValid && descReady && !reinit;

  ////////////////////////////////////////////////////////////////////////////
  property p_reinit_clear;
    reinit && !descValid |=> modeOptions == MODE_RESET;
  endproperty
  a_reinit_clear: assert property (p_reinit_clear) else $error("mode options not cleared");
  property p_mode_load;
    take |=> modeOptions == $past(desc.primaryModeField);
  endproperty
  a_mode_load: assert property (p_mode_load) else $error("mode not taken from header");
  property p_rsvd_bit;
    take && desc.primaryModeField[RSVD_BIT] |=> jobErr.dataErr;
  endproperty
  a_rsvd_bit: assert property (p_rsvd_bit) else $error("reserved bit accepted");
  property p_rsvd_cm;
    take && desc.primaryModeField[CM_HI_BIT:CM_LO_BIT] == CM_RSVD |=> jobErr.dataErr;
  endproperty
  a_rsvd_cm: assert property (p_rsvd_cm) else $error("reserved cipher mode accepted");
  property p_ext_cm;
    take && desc.extMode && desc.primaryModeField[CM_HI_BIT:CM_LO_BIT] != CM_ECB |=> jobErr.dataErr;
  endproperty
  a_ext_cm: assert property (p_ext_cm) else $error("extended mode clash accepted");
  property p_clash;
    busy && descValid && !reinit && desc.primaryModeField != modeOptions |=> jobErr.ctxErr;
  endproperty
  a_clash: assert property (p_clash) else $error("mode change in flight not flagged");
  property p_err_stop;
    $rose(jobErr.dataErr) |-> !inReady && !outValid ##1 jobDone && !busy;
  endproperty
  a_err_stop: assert property (p_err_stop) else $error("bad job not stopped");
  property p_ctx_stop;
    $rose(jobErr.ctxErr) |=> jobDone;
  endproperty
  a_ctx_stop: assert property (p_ctx_stop) else $error("aborted job not ended");
  property p_accept_busy;
    take |=> busy && !descReady;
  endproperty
  a_accept_busy: assert property (p_accept_busy) else $error("accepted job not busy");
  property p_done_pulse;
    jobDone |-> !busy ##1 !jobDone;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done not a single pulse");

  c_accept: cover property (take);
  c_data_err: cover property ($rose(jobErr.dataErr));
  c_ctx_err: cover property ($rose(jobErr.ctxErr));
  c_ctx_out: cover property (outValid && outReady && outData.kind == OUT_CONTEXT);
endmodule // block_cipher_unit_properties

bind block_cipher_unit block_cipher_unit_properties u_props (
  .clk_sys(clk_sys), .nrst(nrst), .reinit(reinit), .descValid(descValid),
  .descReady(descReady), .desc(desc), .inReady(inReady), .outValid(outValid),
  .outReady(outReady), .outData(outData), .jobDone(jobDone), .jobErr(jobErr),
  .busy(busy), .modeOptions(modeOptions)
);

// ==== sim/block_cipher_unit_partner.sv ====
// Channel-side model: feeds key, context and data words, drains results
`timescale 1ns/1ps

module block_cipher_unit_partner
  import block_cipher_unit_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              inReady,
  output logic                   inValid,
  output logic [WORD_W-1:0]      inWord,
  input  wire logic              outValid,
  input  wire out_word_t         outData,
  output logic                   outReady,
  input  wire logic [1:0]        rnd
);
  logic [WORD_W-1:0] feed[$];
  out_word_t         got[$];

  initial begin
    inValid = 1'b0;
    inWord = '0;
    outReady = 1'b0;
  end
  // Released lines show the inverse so stale data cannot pass
  always @(posedge clk_sys) begin
    if (inValid && inReady) begin
      void'(feed.pop_front());
      inValid <= 1'b0;
      inWord <= ~inWord;
    end
    if (outValid && outReady) begin
      got.push_back(outData);
    end
  end
  // A word stays offered until taken; stalls on both sides
  always @(negedge clk_sys) begin
    if (!inValid && feed.size() > 0 && rnd[0]) begin
      inValid <= 1'b1;
      inWord <= feed[0];
    end
    outReady <= rnd[1];
  end
  task automatic flush();
    feed.delete();
    got.delete();
    inValid <= 1'b0;
  endtask
endmodule // block_cipher_unit_partner

// ==== sim/block_cipher_unit_tb_top.sv ====
// Self-checking bench for the block cipher unit with a reference model
`timescale 1ns/1ps

module block_cipher_unit_tb_top import block_cipher_unit_pkg::*;;
  logic               clk_sys = 1'b0;
  logic               nrst = 1'b0;
  logic               reinit = 1'b0;
  logic               descValid = 1'b0;
  descriptor_t        desc = '0;
  logic               descReady, inValid, inReady, outValid, outReady, jobDone, busy;
  logic [WORD_W-1:0]  inWord;
  out_word_t          outData;
  job_error_t         jobErr;
  logic [MODE_W-1:0]  modeOptions;
  logic [31:0]        seed = 32'h63205aa9;
  logic [31:0]        st = 32'h63205aa9;
  int                 err_count = 0;
  int                 n_tests = 0;
  int                 cyc = 0;
  logic [BLOCK_W-1:0] k, iv, ctr, b, o, mac, c0;
  logic [WORD_W-1:0]  w[7];
  out_word_t          exp[$];

  block_cipher_unit u_dut (
    .clk_sys(clk_sys), .nrst(nrst), .reinit(reinit), .descValid(descValid), .descReady(descReady),
    .desc(desc), .inValid(inValid), .inWord(inWord), .inReady(inReady), .outValid(outValid),
    .outReady(outReady), .outData(outData), .jobDone(jobDone), .jobErr(jobErr), .busy(busy),
    .modeOptions(modeOptions));
  block_cipher_unit_partner u_part (
    .clk_sys(clk_sys), .inReady(inReady), .inValid(inValid), .inWord(inWord), .outValid(outValid),
    .outData(outData), .outReady(outReady), .rnd(st[1:0]));

  always #5 clk_sys = ~clk_sys;
  always @(negedge clk_sys) st <= lfsr(st);
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [BLOCK_W-1:0] ciph(input logic [BLOCK_W-1:0] x);
    logic [BLOCK_W-1:0] t;
    t = x ^ k;
    return {t[119:0], t[127:120]};
  endfunction
  function automatic logic [BLOCK_W-1:0] deciph(input logic [BLOCK_W-1:0] x);
    return {x[7:0], x[127:8]} ^ k;
  endfunction
  task automatic rw(output logic [WORD_W-1:0] v);
    seed = lfsr(seed);
    v[31:0] = seed;
    seed = lfsr(seed);
    v[63:32] = seed;
  endtask
  task automatic check(input logic [64:0] seen, input logic [64:0] expv);
    n_tests++;
    if (seen !== expv) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, expv);
    end
  endtask
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic wait_done();
    for (int i = 0; i < 400; i++) begin
      @(posedge clk_sys);
      if (jobDone === 1'b1) return;
    end
    check(1'b0, 1'b1);
  endtask

  // Loads the partner, predicts the result words, runs one descriptor
  task automatic job(input logic [5:0] pm, input logic ext, input logic [5:0] kl,
                     input logic [15:0] dl, input logic [5:0] co, input logic bad);
    logic [WORD_W-1:0] kw[4];
    logic [WORD_W-1:0] t0, t1;
    exp.delete();
    for (int i = 0; i < 4; i++) begin
      rw(kw[i]);
      if (i >= kl / 8) kw[i] = '0;
      else if (!bad) u_part.feed.push_back(kw[i]);
    end
    k = {kw[1], kw[0]} ^ {kw[3], kw[2]};
    for (int i = 0; i < 7; i++) begin
      rw(w[i]);
      if (i == 3 || (i == 2 && !(ext && !pm[0]))) w[i] = '0;
      if (i == 6) w[i] = 64'h8;
      if (!bad) u_part.feed.push_back(w[i]);
    end
    iv = {w[1], w[0]};
    ctr = {w[5], w[4]};
    c0 = ctr;
    mac = pm[4] ? ciph(iv) : iv;
    if (ext) ctr[63:0] = ctr[63:0] + 64'h1;
    for (int n = 0; n < dl / 16; n++) begin
      rw(t0);
      rw(t1);
      b = {t1, t0};
      if (!bad) u_part.feed.push_back(t0);
      if (!bad) u_part.feed.push_back(t1);
      if (ext) begin
        o = b ^ ciph(ctr);
        mac = ciph(mac ^ (pm[0] ? b : o));
        ctr[63:0] = ctr[63:0] + 64'h1;
      end else case (pm[2:1])
        CM_ECB: o = pm[0] ? ciph(b) : deciph(b);
        CM_CBC: begin
          o = pm[0] ? ciph(b ^ iv) : deciph(b) ^ iv;
          iv = pm[0] ? o : b;
        end
        default: begin
          o = b ^ ciph(ctr);
          ctr[63:0] = ctr[63:0] + 64'h1;
        end
      endcase
      exp.push_back({OUT_DATA, o[63:0]});
      exp.push_back({OUT_DATA, o[127:64]});
    end
    w[0] = iv[63:0];
    w[1] = iv[127:64];
    w[4] = ctr[63:0];
    w[5] = ctr[127:64];
    if (ext) begin
      o = pm[5] ? mac ^ ciph(c0) : mac;
      b = pm[0] ? ctr : {w[3], w[2]} ^ ciph(c0);
      {w[1], w[0]} = o;
      {w[3], w[2]} = b;
    end
    for (int i = 0; i < co / 8; i++) exp.push_back({OUT_CONTEXT, w[i]});
    if (bad) exp.delete();
    @(negedge clk_sys);
    desc = '{hdrType: HDR_TYPE_COMMON, extMode: ext, primaryModeField: pm, keyLen: kl,
             ctxInLen: CTX_LEN_FULL, dataLen: dl, ctxOutLen: co};
    descValid = 1'b1;
    @(negedge clk_sys);
    descValid = 1'b0;
    wait_done();
    @(negedge clk_sys);
    check(jobErr, {bad, 1'b0});
    check(modeOptions, pm);
    check(65'(u_part.got.size()), 65'(exp.size()));
    foreach (exp[i]) check(u_part.got[i], exp[i]);
    u_part.got.delete();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    nrst = 1'b1;
    check(modeOptions, MODE_RESET);
    job(6'h01, 1'b0, KEY_LEN_16, 16'h20, LEN_NONE, 1'b0);
    job(6'h00, 1'b0, KEY_LEN_24, 16'h30, CTX_LEN_FULL, 1'b0);
    job(6'h03, 1'b0, KEY_LEN_32, 16'h40, CTX_LEN_FULL, 1'b0);
    job(6'h02, 1'b0, KEY_LEN_16, 16'h20, CTX_LEN_FULL, 1'b0);
    job(6'h06, 1'b0, KEY_LEN_24, 16'h10, CTX_LEN_FULL, 1'b0);
    job(6'h07, 1'b0, KEY_LEN_32, 16'h20, CTX_LEN_FULL, 1'b0);
    job(6'h09, 1'b0, KEY_LEN_16, 16'h20, LEN_NONE, 1'b1);
    job(6'h04, 1'b0, KEY_LEN_16, 16'h20, LEN_NONE, 1'b1);
    job(6'h02, 1'b1, KEY_LEN_16, 16'h20, LEN_NONE, 1'b1);
    job(6'h01, 1'b0, 6'h08, 16'h20, LEN_NONE, 1'b1);
    job(6'h01, 1'b0, KEY_LEN_16, 16'h18, LEN_NONE, 1'b1);
    job(6'h31, 1'b1, KEY_LEN_16, 16'h20, CTX_LEN_CCM_LONG, 1'b0);
    job(6'h20, 1'b1, KEY_LEN_32, 16'h10, CTX_LEN_CCM_SHORT, 1'b0);
    job(6'h10, 1'b1, KEY_LEN_24, 16'h20, CTX_LEN_CCM_LONG, 1'b0);
    job(6'h03, 1'b0, KEY_LEN_32, 16'h40, CTX_LEN_FULL, 1'b0);
    // Header mode field altered while the key is still loading
    repeat (11) u_part.feed.push_back('0);
    @(negedge clk_sys);
    descValid = 1'b1;
    @(negedge clk_sys);
    descValid = 1'b0;
    repeat (3) @(negedge clk_sys);
    desc.primaryModeField = 6'h06;
    descValid = 1'b1;
    @(negedge clk_sys);
    descValid = 1'b0;
    wait_done();
    u_part.flush();
    @(negedge clk_sys);
    check(jobErr, 2'h1);
    reinit = 1'b1;
    @(negedge clk_sys);
    reinit = 1'b0;
    check(modeOptions, MODE_RESET);
    complete_run();
  end
endmodule // block_cipher_unit_tb_top
